// ===== rtl/wrbs_top.sv
// Purpose: wake from power-down, power-on reset and boot strap sequencer
// Assumes: 200 MHz core clock, supply comparators and interrupts as pins
// Notes: registers over AXI4-Lite, one write and one read at a time
`include "wrbs_params.svh"
module wrbs_top
  import wrbs_pkg::*;
#(
  parameter int unsigned POR_DELAY_CYC = `WRBS_POR_DELAY_CYC,
  parameter int AW = 16
) (
  input wire logic CLK,
  input wire logic RST,
  input wire wrbs_pkg::wrbs_axi_req_s AXI_REQ,
  output wrbs_pkg::wrbs_axi_rsp_s AXI_RSP,
  input wire logic SUPPLY_ABOVE_2V45,
  input wire logic SUPPLY_ABOVE_4V5,
  input wire logic SUPPLY_ABOVE_1V,
  input wire logic VERSION_5V,
  input wire logic RESET_PIN,
  input wire logic IC_IRQ,
  input wire logic SERIAL_IRQ,
  input wire logic EXT_IRQ_ZERO_N,
  input wire logic STROBE_I,
  output logic STROBE_O,
  output logic STROBE_OE,
  input wire logic CORE_STROBE,
  input wire logic MEMSEL_I,
  output logic MEMSEL_O,
  output logic MEMSEL_OE,
  input wire logic EMU_TX,
  input wire logic EMU_TX_EN,
  output logic EMU_RX,
  input wire logic [AW-1:0] CORE_NEXT_PC,
  output logic CORE_RST,
  output logic CORE_CLK_EN,
  output logic PERIPH_EN,
  output logic IC_EN,
  output logic PORT_HOLD,
  output logic WAKE_IRQ,
  output logic [1:0] WAKE_SRC,
  output logic [AW-1:0] RESUME_PC,
  output logic BOOT_SERIAL,
  output logic EMUL_MODE
);
  import wrbs_pkg::*;

  // synchronised pins
  logic [9:0] pins_s;
  logic hi3_s, hi5_s, hi1_s, v5_s, rpin_s, ic_s, ser_s, ext0n_s, strb_s, msel_s;
  wrbs_sync #(.W(10), .INIT(10'h0A4)) u_sync (
    .CLK(CLK),
    .RST(RST),
    .D({SUPPLY_ABOVE_2V45, SUPPLY_ABOVE_4V5, SUPPLY_ABOVE_1V, VERSION_5V,
        RESET_PIN, IC_IRQ, SERIAL_IRQ, EXT_IRQ_ZERO_N, STROBE_I, MEMSEL_I}),
    .Q(pins_s)
  );
  assign {hi3_s, hi5_s, hi1_s, v5_s, rpin_s, ic_s, ser_s, ext0n_s, strb_s, msel_s} = pins_s;

  wrbs_state_e state_q; // sequencer state
  logic [31:0] por_cnt_q; // power-on delay counter
  logic [3:0] ctrl_q; // power_control_register
  logic rst_prev_q; // reset level last cycle, for the release edge
  logic above_thr; // supply above the version's threshold
  logic pd_enter; // power-down taken this cycle
  logic wake_ic, wake_ser, wake_ext0, wake_any;
  logic serial_wake_enable, ext_irq_zero_wake_enable;

  assign serial_wake_enable = ctrl_q[`WRBS_CTRL_SER_BIT];
  assign ext_irq_zero_wake_enable = ctrl_q[`WRBS_CTRL_EXT0_BIT];
  // threshold follows the part's supply version
  assign above_thr = v5_s ? hi5_s : hi3_s;
  assign pd_enter = (state_q == ST_RUN) && ctrl_q[`WRBS_CTRL_PD_BIT] && !rpin_s;
  // wake qualification; serial and ext zero count only when enabled, the IC interrupt always counts
  assign wake_ic = ic_s;
  assign wake_ser = ser_s && serial_wake_enable;
  assign wake_ext0 = !ext0n_s && ext_irq_zero_wake_enable;
  assign wake_any = wake_ic || wake_ser || wake_ext0;

  // sequencer: supply watch, timer, run and power-down
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q <= ST_OFF;
    end else if (!hi1_s) begin
      state_q <= ST_OFF;
    end else begin
      case (state_q)
        ST_OFF: begin
          if (above_thr) state_q <= ST_TIMER;
          else state_q <= ST_HOLD;
        end
        ST_HOLD: begin
          // stays in reset while above 1 V but under threshold
          if (above_thr) state_q <= ST_TIMER;
        end
        ST_TIMER: begin
          if (!above_thr) state_q <= ST_HOLD;
          else if (por_cnt_q == POR_DELAY_CYC - 1) state_q <= ST_RUN;
        end
        ST_RUN: begin
          if (!above_thr) state_q <= ST_HOLD;
          else if (pd_enter) state_q <= ST_PDOWN;
        end
        ST_PDOWN: begin
          // pin reset or first qualifying wake ends power-down
          if (!above_thr) state_q <= ST_HOLD;
          else if (rpin_s || wake_any) state_q <= ST_RUN;
        end
        default: state_q <= ST_OFF;
      endcase
    end
  end

  // power-on delay counter, restarts whenever the timer is left
  always_ff @(posedge CLK) begin
    if (RST || state_q != ST_TIMER) begin
      por_cnt_q <= 32'h0;
    end else begin
      por_cnt_q <= por_cnt_q + 32'h1;
    end
  end

  // core reset covers supply reset and the reset pin
  assign CORE_RST = (state_q != ST_RUN && state_q != ST_PDOWN) || rpin_s;
  // clocks and peripherals shut in power-down, the IC only when its enable bit is clear; ports keep levels
  assign CORE_CLK_EN = (state_q == ST_RUN) && !rpin_s;
  assign PERIPH_EN = CORE_CLK_EN;
  assign IC_EN = CORE_CLK_EN || (state_q == ST_PDOWN && ctrl_q[`WRBS_CTRL_IC_BIT]);
  assign PORT_HOLD = (state_q == ST_PDOWN);

  // release edge of reset: the strap sample point
  always_ff @(posedge CLK) begin
    if (RST) rst_prev_q <= 1'b1;
    else rst_prev_q <= CORE_RST;
  end

  // straps caught once per reset release; a low strobe means download, a high memory select means debug
  always_ff @(posedge CLK) begin
    if (RST) begin
      BOOT_SERIAL <= 1'b0;
      EMUL_MODE <= 1'b0;
    end else if (rst_prev_q && !CORE_RST) begin
      BOOT_SERIAL <= !strb_s;
      EMUL_MODE <= msel_s;
    end
  end

  // strobe pin is released while in reset so the strap can be read
  assign STROBE_OE = !CORE_RST;
  assign STROBE_O = CORE_STROBE;
  // memory select pin doubles as the emulation link in emulation mode
  assign MEMSEL_OE = EMUL_MODE && EMU_TX_EN && !CORE_RST;
  assign MEMSEL_O = EMU_TX;
  assign EMU_RX = EMUL_MODE ? msel_s : 1'b1;

  // wake pulse, source and resume point
  always_ff @(posedge CLK) begin
    if (RST || CORE_RST) begin
      WAKE_IRQ <= 1'b0;
      WAKE_SRC <= `WRBS_SRC_NONE;
      RESUME_PC <= '0;
    end else begin
      WAKE_IRQ <= 1'b0;
      if (pd_enter) begin
        RESUME_PC <= CORE_NEXT_PC;
      end
      if (state_q == ST_PDOWN && wake_any) begin
        // fixed priority picks one source when several arrive together
        WAKE_IRQ <= 1'b1;
        if (wake_ic) WAKE_SRC <= `WRBS_SRC_IC;
        else if (wake_ser) WAKE_SRC <= `WRBS_SRC_SER;
        else WAKE_SRC <= `WRBS_SRC_EXT0;
      end
    end
  end

  // bus slave: address and data held until both arrive
  logic aw_q, w_q, bvalid_q, rvalid_q;
  logic [7:0] awaddr_q, araddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic do_wr, wr_hit;
  assign do_wr = aw_q && w_q && !bvalid_q;
  assign wr_hit = (awaddr_q == `WRBS_ADDR_CTRL);

  // write channels
  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `WRBS_RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      if (AXI_REQ.awvalid && AXI_RSP.awready) begin
        aw_q <= 1'b1;
        awaddr_q <= AXI_REQ.awaddr;
      end
      if (AXI_REQ.wvalid && AXI_RSP.wready) begin
        w_q <= 1'b1;
        wdata_q <= AXI_REQ.wdata;
        wstrb_q <= AXI_REQ.wstrb;
      end
      if (do_wr) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `WRBS_RESP_OKAY : `WRBS_RESP_SLVERR;
      end else if (bvalid_q && AXI_REQ.bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // control register; defaults return on any core reset
  always_ff @(posedge CLK) begin
    if (RST || CORE_RST) begin
      ctrl_q <= `WRBS_CTRL_RESET;
    end else begin
      if (do_wr && wr_hit && wstrb_q[0]) ctrl_q <= wdata_q[3:0];
      // request bit clears once power-down is taken; a new write wins
      else if (state_q == ST_PDOWN) ctrl_q[`WRBS_CTRL_PD_BIT] <= 1'b0;
    end
  end

  // read channel, answered one cycle after the address is taken
  always_ff @(posedge CLK) begin
    if (RST) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `WRBS_RESP_OKAY;
      araddr_q <= 8'h00;
    end else if (AXI_REQ.arvalid && AXI_RSP.arready) begin
      rvalid_q <= 1'b1;
      araddr_q <= AXI_REQ.araddr;
      rresp_q <= `WRBS_RESP_OKAY;
      case (AXI_REQ.araddr)
        `WRBS_ADDR_CTRL: rdata_q <= {28'h0, ctrl_q};
        `WRBS_ADDR_STAT: rdata_q <= {24'h0, EMUL_MODE, BOOT_SERIAL, WAKE_SRC,
                                     1'b0, 3'(state_q)};
        `WRBS_ADDR_RESUME: rdata_q <= 32'(RESUME_PC);
        default: begin
          rdata_q <= 32'h0;
          rresp_q <= `WRBS_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && AXI_REQ.rready) begin
      rvalid_q <= 1'b0;
    end
  end

  always_comb begin
    AXI_RSP.awready = !aw_q && !bvalid_q;
    AXI_RSP.wready = !w_q && !bvalid_q;
    AXI_RSP.bvalid = bvalid_q;
    AXI_RSP.bresp = bresp_q;
    AXI_RSP.arready = !rvalid_q;
    AXI_RSP.rvalid = rvalid_q;
    AXI_RSP.rdata = rdata_q;
    AXI_RSP.rresp = rresp_q;
  end

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence in_pd_s;
    state_q == ST_PDOWN && !rpin_s && above_thr && hi1_s;
  endsequence
  sequence woke_s;
    state_q == ST_RUN && WAKE_IRQ;
  endsequence
  sequence release_s;
    rst_prev_q && !CORE_RST;
  endsequence

  ic_wake_a: assert property (in_pd_s ##0 ic_s |=> woke_s ##0 WAKE_SRC == `WRBS_SRC_IC)
    else $error("interval wake missed");
  resume_pc_a: assert property (pd_enter |=> (RESUME_PC == $past(CORE_NEXT_PC))
    throughout (state_q == ST_PDOWN)[*1])
    else $error("resume point not held");
  ser_gate_a: assert property (in_pd_s ##0 (!ic_s && !wake_ext0 && !serial_wake_enable)
    |=> state_q == ST_PDOWN)
    else $error("disabled serial wake");
  ext0_gate_a: assert property (in_pd_s ##0 (!ic_s && !wake_ser && !ext_irq_zero_wake_enable)
    |=> !WAKE_IRQ)
    else $error("disabled ext zero wake");
  supply_hold_a: assert property (!above_thr |=> CORE_RST)
    else $error("reset not held on low supply");
  por_time_a: assert property (state_q == ST_TIMER && $past(state_q) != ST_TIMER
    && above_thr |-> CORE_RST ##1 CORE_RST)
    else $error("timer released early");
  por_end_a: assert property (state_q == ST_RUN && $past(state_q) == ST_TIMER
    |-> $past(por_cnt_q) == POR_DELAY_CYC - 1)
    else $error("timer length wrong");
  low_off_a: assert property (!hi1_s |=> state_q == ST_OFF && CORE_RST)
    else $error("not off below 1 V");
  strap_take_a: assert property (release_s |=> BOOT_SERIAL == !$past(strb_s))
    else $error("strap not sampled");
  strobe_rel_a: assert property (CORE_RST |-> !STROBE_OE)
    else $error("strobe driven in reset");
  pd_quiet_a: assert property (state_q == ST_PDOWN |-> !PERIPH_EN && !CORE_CLK_EN)
    else $error("peripherals live in power-down");
  pin_reset_a: assert property (rpin_s |-> CORE_RST ##1 (ctrl_q == `WRBS_CTRL_RESET))
    else $error("pin reset ignored");
endmodule

// ===== rtl/wrbs_params.svh
// Purpose: constants of the wake, reset and boot sequencer
// Assumes: included by its bare name
// Notes: byte addresses of one aligned 32-bit word each
`ifndef WRBS_PARAMS_SVH
`define WRBS_PARAMS_SVH
// register byte addresses
`define WRBS_ADDR_CTRL 8'h00
`define WRBS_ADDR_STAT 8'h04
`define WRBS_ADDR_RESUME 8'h08
// power_control_register fields
`define WRBS_CTRL_PD_BIT 0
`define WRBS_CTRL_SER_BIT 1
`define WRBS_CTRL_EXT0_BIT 2
`define WRBS_CTRL_IC_BIT 3
`define WRBS_CTRL_RESET 4'h0
// bus responses
`define WRBS_RESP_OKAY 2'h0
`define WRBS_RESP_SLVERR 2'h2
// power-on timer: time in ms and clock rate in MHz
`define WRBS_POR_DELAY_MS 128
`define WRBS_CLK_MHZ 200
`define WRBS_POR_DELAY_CYC (`WRBS_POR_DELAY_MS * 1000 * `WRBS_CLK_MHZ)
// wake source codes
`define WRBS_SRC_NONE 2'h0
`define WRBS_SRC_IC 2'h1
`define WRBS_SRC_SER 2'h2
`define WRBS_SRC_EXT0 2'h3
`endif

// ===== rtl/wrbs_pkg.sv
// Purpose: types of the wake, reset and boot sequencer
// Assumes: nothing
// Notes: bus signal names kept as published
package wrbs_pkg;
  // sequencer states
  typedef enum logic [2:0] {
    ST_OFF, ST_HOLD, ST_TIMER, ST_RUN, ST_PDOWN
  } wrbs_state_e;
  // master to slave
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } wrbs_axi_req_s;
  // slave to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } wrbs_axi_rsp_s;
endpackage

// ===== rtl/wrbs_sync.sv
// Purpose: two-flop synchroniser for a group of pins
// Assumes: one clock, synchronous active-high reset
// Notes: first stage feeds only the second stage
module wrbs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [W-1:0] D,
  output logic [W-1:0] Q
);
  logic [W-1:0] meta_q; // first stage, read only by the second stage
  // both stages settle to the idle level under reset
  always_ff @(posedge CLK) begin
    if (RST) begin
      meta_q <= INIT;
      Q <= INIT;
    end else begin
      meta_q <= D;
      Q <= meta_q;
    end
  end
endmodule

// ===== verif/wrbs_partner.sv
// Purpose: board around the sequencer: strap jumper, emulation pull, interrupt sources
// Assumes: the strobe pin has a pull-up, the memory select pin is strapped hard
// Notes: sources are raised for four cycles and then drop on their own
module wrbs_partner (
  input wire logic clk,
  input wire logic jumper,
  input wire logic emu_pull,
  input wire logic strobe_o,
  input wire logic strobe_oe,
  input wire logic memsel_o,
  input wire logic memsel_oe,
  output logic strobe_i,
  output logic memsel_i,
  output logic ic_irq,
  output logic serial_irq,
  output logic ext_irq_zero_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0; // cycles left on the raised source
  // while the part does not drive it, only the download jumper pulls the strobe low; otherwise the pull-up wins
  assign strobe_i = strobe_oe ? strobe_o : !jumper;
  // emulation pull or hard strap whenever the part does not drive the pin
  assign memsel_i = memsel_oe ? memsel_o : emu_pull;
  initial begin
    ic_irq = 1'b0;
    serial_irq = 1'b0;
    ext_irq_zero_n = 1'b1;
  end
  // raise one source; ext zero is only fired once the part already sleeps
  task automatic fire(input int src);
    ic_irq <= (src == 1);
    serial_irq <= (src == 2);
    ext_irq_zero_n <= (src != 3);
    cnt <= 4;
  endtask
  // drop every source after its hold time so a later entry is not disturbed
  always @(posedge clk) begin
    if (cnt != 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        ic_irq <= 1'b0;
        serial_irq <= 1'b0;
        ext_irq_zero_n <= 1'b1;
      end
    end
  end
endmodule

// ===== verif/wrbs_top_test.sv
// Purpose: self-checking bench of the wake, reset and boot sequencer
// Assumes: power-on delay shortened to 20 cycles
// Notes: registers reached over the AXI4-Lite tasks only
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("mismatch at %0t got %0h exp %0h", $time, (a), (b)); end end
`define WAITC(c) for (int k = 0; k < 200 && !(c); k++) @(posedge CLK);
module wrbs_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import wrbs_pkg::*;
  logic CLK = 0, RST = 1, s245 = 1, s45 = 1, s1 = 1, ver = 0, rpin = 0, jmp = 0, emu = 0;
  logic stb_i, stb_o, stb_oe, ms_i, ms_o, ms_oe, icq, serq, ext_n, core_rst, wirq, boot, emul;
  logic pd_hold, clk_en, per_en, ic_en;
  logic cstb = 1, etx = 0, eten = 0, erx; // core strobe, emulation link drive and receive
  logic [1:0] wsrc, r;
  logic [15:0] pc = 16'h0000, rpc;
  logic [31:0] d;
  wrbs_axi_req_s req = '0;
  wrbs_axi_rsp_s rsp;
  int mismatches = 0, n_checks = 0;
  // 200 MHz core clock
  always #2.5 CLK = ~CLK;
  wrbs_partner P (.clk(CLK), .jumper(jmp), .emu_pull(emu), .strobe_o(stb_o),
    .strobe_oe(stb_oe), .memsel_o(ms_o), .memsel_oe(ms_oe), .strobe_i(stb_i),
    .memsel_i(ms_i), .ic_irq(icq), .serial_irq(serq), .ext_irq_zero_n(ext_n));
  wrbs_top #(.POR_DELAY_CYC(20)) DUT (.CLK(CLK), .RST(RST), .AXI_REQ(req), .AXI_RSP(rsp),
    .SUPPLY_ABOVE_2V45(s245), .SUPPLY_ABOVE_4V5(s45), .SUPPLY_ABOVE_1V(s1),
    .VERSION_5V(ver), .RESET_PIN(rpin), .IC_IRQ(icq), .SERIAL_IRQ(serq),
    .EXT_IRQ_ZERO_N(ext_n), .STROBE_I(stb_i), .STROBE_O(stb_o), .STROBE_OE(stb_oe),
    .CORE_STROBE(cstb), .MEMSEL_I(ms_i), .MEMSEL_O(ms_o), .MEMSEL_OE(ms_oe),
    .EMU_TX(etx), .EMU_TX_EN(eten), .EMU_RX(erx), .CORE_NEXT_PC(pc), .CORE_RST(core_rst),
    .CORE_CLK_EN(clk_en), .PERIPH_EN(per_en), .IC_EN(ic_en), .PORT_HOLD(pd_hold),
    .WAKE_IRQ(wirq), .WAKE_SRC(wsrc), .RESUME_PC(rpc), .BOOT_SERIAL(boot), .EMUL_MODE(emul));
  // one write: address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge CLK);
    req.awaddr <= a;
    req.wdata <= v;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    // no cycle count assumed: only the watchdog ends a hung wait
    forever begin
      @(posedge CLK);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) begin
        rs = rsp.bresp;
        req.bready <= 1'b0;
        break;
      end
    end
  endtask
  // one read; rready held until the data are seen
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge CLK);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    forever begin
      @(posedge CLK);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) begin
        v = rsp.rdata;
        rs = rsp.rresp;
        req.rready <= 1'b0;
        break;
      end
    end
  endtask
  // supply dip for one version, then rise with a given strap setting
  task automatic por(input logic v, input logic j, input logic e);
    int n;
    ver <= v;
    jmp <= j;
    emu <= e;
    s45 <= 1'b0;
    if (!v) s245 <= 1'b0;
    repeat (4) @(posedge CLK);
    `CHK(core_rst, 1'b1)
    axr(8'h04, d, r);
    `CHK(d[2:0], 3'h1)
    s1 <= 1'b0;
    repeat (4) @(posedge CLK);
    axr(8'h04, d, r);
    `CHK(d[2:0], 3'h0)
    s1 <= 1'b1;
    s245 <= 1'b1;
    s45 <= 1'b1;
    n = 0;
    while (core_rst !== 1'b0 && n < 100) begin
      @(posedge CLK);
      n++;
    end
    `CHK(n >= 20 && n <= 30, 1'b1)
    repeat (2) @(posedge CLK);
    `CHK(boot, j)
    `CHK(emul, e)
    // running: strobe is driven by the core, memory select carries the link only in emulation
    jmp <= 1'b0;
    cstb <= 1'b0;
    etx <= 1'b0;
    eten <= 1'b1;
    repeat (4) @(posedge CLK);
    `CHK({stb_oe, stb_i}, 2'b10)
    `CHK({ms_oe, erx}, {e, !e})
    cstb <= 1'b1;
    etx <= 1'b1;
    eten <= 1'b0;
  endtask
  // put the part to sleep and check what stays powered
  task automatic sleep(input logic [3:0] c);
    axw(8'h00, {28'h0, c}, r);
    repeat (3) @(posedge CLK);
    `CHK({pd_hold, per_en, clk_en, ic_en}, {3'b100, c[3]})
  endtask
  // wake from one source, then check vector, source and resume point
  task automatic wake(input int s, input logic [15:0] p);
    P.fire(s);
    `WAITC(wirq === 1'b1)
    `CHK({wirq, clk_en, wsrc}, {2'b11, s[1:0]})
    `CHK(rpc, p)
    axr(8'h08, d, r);
    `CHK(d[15:0], p)
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    #50000;
    mismatches++;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    `WAITC(core_rst === 1'b0)
    `CHK(core_rst, 1'b0)
    por(1'b1, 1'b0, 1'b1);
    por(1'b0, 1'b1, 1'b0);
    por(1'b0, 1'b0, 1'b0);
    axr(8'h0C, d, r);
    `CHK({r, d}, {2'h2, 32'h0})
    pc <= 16'h1234;
    sleep(4'h1);
    P.fire(2);
    repeat (6) @(posedge CLK);
    P.fire(3);
    repeat (8) @(posedge CLK);
    `CHK(pd_hold, 1'b1)
    wake(1, 16'h1234);
    for (int i = 0; i < 3; i++) begin
      pc <= 16'h2000 + 16'(i);
      sleep(i == 0 ? 4'h3 : i == 1 ? 4'h5 : 4'h9);
      wake(i == 0 ? 2 : i == 1 ? 3 : 1, 16'h2000 + 16'(i));
    end
    sleep(4'h7);
    rpin <= 1'b1;
    repeat (4) @(posedge CLK);
    `CHK({core_rst, pd_hold}, 2'b10)
    rpin <= 1'b0;
    axr(8'h00, d, r);
    `CHK(d[3:0], 4'h0)
    `WAITC(core_rst === 1'b0)
    `CHK({core_rst, wsrc, boot}, 4'h0)
    print_verdict;
  end
endmodule
